//--- design/light_cfg_pkg.sv
// constants for the light persistence and pulse configuration block
// assumes a 20 mhz ref_clk and an 8-bit register port
`default_nettype none
package light_cfg_pkg;
   localparam logic [7:0] general_config_addr = 8'h8d;
   localparam logic [7:0] pulse_config_addr   = 8'h8e;
   localparam logic [7:0] persistence_addr    = 8'h8c;
   localparam logic [7:0] general_config_rst  = 8'h00;
   localparam logic [7:0] pulse_config_rst    = 8'h00;
   localparam logic [7:0] persistence_rst     = 8'h00;
   localparam logic [7:0] general_config_mask = 8'h24;
   localparam int idle_power_saving_bit = 5;
   localparam int long_wait_bit         = 2;
   localparam int pulse_length_lsb      = 6;
   localparam int pulse_count_lsb       = 0;
   localparam int ambient_persistence_register_lsb      = 0;
   localparam int long_wait_factor      = 12;
   localparam int clk_mhz               = 20;
   localparam int pulse_base_us         = 4;
   localparam logic [9:0] pulse_base_cycles = 10'(pulse_base_us * clk_mhz);
   localparam int pulse_gap_us          = 4;
   localparam logic [9:0] pulse_gap_cycles = 10'(pulse_gap_us * clk_mhz);
   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_on    = 2'b01,
      st_off   = 2'b10
   } pulse_state_e;
endpackage
`default_nettype wire

//--- design/ambient_persist_filter.sv
// consecutive out-of-range filter for clear-channel results
// assumes one result_valid pulse per completed ambient cycle
`timescale 1ns/1ps
`default_nettype none
module ambient_persist_filter
   import light_cfg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  ambient_persistence,
   input  wire logic        result_valid,
   input  wire logic [15:0] clear_channel_result,
   input  wire logic [15:0] ambient_low_threshold,
   input  wire logic [15:0] ambient_high_threshold,
   input  wire logic        pending_clear,
   output logic             ambient_int_pending,
   output logic [5:0]       out_of_range_count
);
   function automatic logic [5:0] required_count(input logic [3:0] p);
      if (p <= 4'h3)
         required_count = {2'b00, p};
      else if (p == 4'h4)
         required_count = 6'h05;
      else
         required_count = 6'(5 * (int'(p) - 3));
   endfunction

   logic       out_range;
   logic [5:0] need;
   logic       hit;
   assign out_range = (clear_channel_result < ambient_low_threshold) ||
                      (clear_channel_result > ambient_high_threshold);
   assign need = required_count(ambient_persistence);
   assign hit  = result_valid &&
                 ((ambient_persistence == 4'h0) ||
                  (out_range && (out_of_range_count + 6'h01 >= need)));

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         out_of_range_count <= 6'h00;
      else if (result_valid)
      begin
         if (!out_range)
            out_of_range_count <= 6'h00;
         else if (out_of_range_count < need)
            out_of_range_count <= out_of_range_count + 6'h01;
      end                                                                  // saturate
   end

   // set wins over clear so an event in the clear cycle is kept
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ambient_int_pending <= 1'b0;
      else if (hit)
         ambient_int_pending <= 1'b1;
      else if (pending_clear)
         ambient_int_pending <= 1'b0;
   end
endmodule // ambient_persist_filter
`default_nettype wire

//--- design/light_persist_and_pulse_config.sv
// registers, idle/wait control and led pulse train for the light sensor
// assumes a synchronous byte register port driven by the serial interface
`timescale 1ns/1ps
`default_nettype none
module light_persist_and_pulse_config
   import light_cfg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [7:0]       reg_rdata,
   input  wire logic        sample_start,
   output logic             led_driver_output,
   output logic             sample_busy,
   input  wire logic        result_valid,
   input  wire logic [15:0] clear_channel_result,
   input  wire logic [15:0] ambient_low_threshold,
   input  wire logic [15:0] ambient_high_threshold,
   input  wire logic        ambient_int_clear,
   output logic             ambient_int_pending,
   input  wire logic [7:0]  wait_base_cycles,
   output logic [11:0]      wait_cycles,
   input  wire logic        functions_idle,
   output logic             low_power
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] general_config;
   logic [7:0] pulse_config;
   logic [7:0] persistence_register;
   logic       write_general;
   logic       write_pulse;
   logic       write_persistence;

   assign write_general     = reg_write && (reg_addr == general_config_addr);
   assign write_pulse       = reg_write && (reg_addr == pulse_config_addr);
   assign write_persistence = reg_write && (reg_addr == persistence_addr);

   // reserved bits are dropped on the way in, so they can never read back set
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         general_config <= general_config_rst;
      else if (write_general)
         general_config <= reg_wdata & general_config_mask;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pulse_config <= pulse_config_rst;
      else if (write_pulse)
         pulse_config <= reg_wdata;
   end

   // upper nibble is stored but unused here
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         persistence_register <= persistence_rst;
      else if (write_persistence)
         persistence_register <= reg_wdata;
   end

   // unmapped addresses read as zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_read)
      begin
         case (reg_addr)
            general_config_addr: reg_rdata <= general_config;
            pulse_config_addr:   reg_rdata <= pulse_config;
            persistence_addr:    reg_rdata <= persistence_register;
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // idle power and wait scaling
   // ************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         low_power   <= 1'b0;
         wait_cycles <= 12'h000;
      end
      else
      begin
         low_power <= general_config[idle_power_saving_bit] && functions_idle;
         if (general_config[long_wait_bit])
            wait_cycles <= 12'(int'(wait_base_cycles) * long_wait_factor);
         else
            wait_cycles <= {4'h0, wait_base_cycles};
      end
   end

   // ************************************************************
   // ambient persistence filter
   // ************************************************************
   ambient_persist_filter u_filter (
      .ref_clk                (ref_clk),
      .rst                    (rst),
      .ambient_persistence    (persistence_register[ambient_persistence_register_lsb +: 4]),
      .result_valid           (result_valid),
      .clear_channel_result   (clear_channel_result),
      .ambient_low_threshold  (ambient_low_threshold),
      .ambient_high_threshold (ambient_high_threshold),
      .pending_clear          (ambient_int_clear),
      .ambient_int_pending    (ambient_int_pending),
      .out_of_range_count     ()
   );

   // ************************************************************
   // led pulse train
   // ************************************************************
   // settings are latched at sample start so a write mid-sample cannot bend a pulse
   pulse_state_e state;
   logic [9:0]   timer;
   logic [9:0]   on_cycles;
   logic [6:0]   pulses_left;
   logic         start_taken;
   logic         on_done;
   logic         off_done;

   function automatic logic [9:0] on_time(input logic [1:0] code);
      on_time = pulse_base_cycles << code;
   endfunction

   assign start_taken = (state == st_idle) && sample_start;
   assign on_done     = (state == st_on) && (timer == 10'h001);
   assign off_done    = (state == st_off) && (timer == 10'h001);

   // phase sequencer; a start while busy is ignored
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         state <= st_idle;
      else
      begin
         case (state)
            st_idle:
               if (sample_start)
                  state <= st_on;
            st_on:
               if (timer == 10'h001)
                  state <= st_off;
            st_off:
               if (timer == 10'h001)
               begin
                  if (pulses_left == 7'h00)
                     state <= st_idle;
                  else
                     state <= st_on;
               end
            default:
               state <= st_idle;
         endcase
      end
   end

   // one down-counter serves both the on phase and the gap
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         timer <= 10'h000;
      else if (start_taken)
         timer <= on_time(pulse_config[pulse_length_lsb +: 2]);
      else if (on_done)
         timer <= pulse_gap_cycles;
      else if (off_done)
         timer <= on_cycles;
      else if (state != st_idle)
         timer <= timer - 10'h001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         on_cycles <= 10'h000;
      else if (start_taken)
         on_cycles <= on_time(pulse_config[pulse_length_lsb +: 2]);
   end

   // loaded with count plus one, so a field of 63 still fits in seven bits
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pulses_left <= 7'h00;
      else if (start_taken)
         pulses_left <= {1'b0, pulse_config[pulse_count_lsb +: 6]} + 7'h01;
      else if (on_done)
         pulses_left <= pulses_left - 7'h01;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         led_driver_output <= 1'b0;
      else
         led_driver_output <= (state == st_on);
   end

   assign sample_busy = (state != st_idle);
endmodule // light_persist_and_pulse_config
`default_nettype wire

//--- testbench/host_port_model.sv
// host side of the byte register port, one access per call
// assumes ref_clk from the bench; requests change 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module host_port_model
(
   input  wire logic       ref_clk,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);
   initial {reg_addr, reg_wdata, reg_write, reg_read} = '0;
   // released address and data lines show the inverse so stale values cannot pass for a match
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      {reg_addr, reg_wdata, reg_write, reg_read} = {a, d, wr, !wr};
      @(posedge ref_clk);
      #1;
      q = reg_rdata;
      {reg_addr, reg_wdata, reg_write, reg_read} = {~a, ~d, 2'b00};
   endtask
endmodule // host_port_model
`default_nettype wire

//--- testbench/light_cfg_assertions.sv
// port checker for the light persistence and pulse block
// assumes one ref_clk domain with synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module light_cfg_checker
   import light_cfg_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       sample_start,
   input wire logic       sample_busy,
   input wire logic       led_driver_output,
   input wire logic       result_valid,
   input wire logic       ambient_int_clear,
   input wire logic       ambient_int_pending,
   input wire logic       functions_idle,
   input wire logic       low_power
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_reserved_read_zero: assert property (reg_read && reg_addr == general_config_addr
      |=> (reg_rdata & ~general_config_mask) == 8'h00) else $error("reserved bits read set");
   a_idle_power_cause: assert property (low_power |-> $past(functions_idle))
      else $error("low power without idle");
   a_led_in_sample: assert property (led_driver_output |-> sample_busy)
      else $error("led on outside a sample");
   a_start_begins: assert property (sample_start && !sample_busy |=> sample_busy)
      else $error("start not taken");
   a_pulse_min_on: assert property ($rose(led_driver_output) |=> led_driver_output[*8])
      else $error("pulse too short");
   a_pulse_gap: assert property ($fell(led_driver_output) |=> !led_driver_output[*8])
      else $error("gap too short");
   a_pending_held: assert property (ambient_int_pending && !ambient_int_clear
      |=> ambient_int_pending) else $error("pending dropped");
   a_pending_cause: assert property ($rose(ambient_int_pending) |-> $past(result_valid))
      else $error("pending without result");
   a_pending_clears: assert property (ambient_int_clear && !result_valid
      |=> !ambient_int_pending) else $error("pending not cleared");
endmodule // light_cfg_checker
bind light_persist_and_pulse_config light_cfg_checker chk (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .sample_start(sample_start), .sample_busy(sample_busy),
   .led_driver_output(led_driver_output), .result_valid(result_valid),
   .ambient_int_clear(ambient_int_clear), .ambient_int_pending(ambient_int_pending),
   .functions_idle(functions_idle), .low_power(low_power));
`default_nettype wire

//--- testbench/light_persist_and_pulse_config_test.sv
// self-checking bench: registers, wait scaling, persistence filter, led train
// assumes the design package; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module light_persist_and_pulse_config_test;
   import light_cfg_pkg::*;
   logic        ref_clk, rst, reg_write, reg_read, sample_start, result_valid;
   logic        ambient_int_clear, functions_idle, led_driver_output, sample_busy;
   logic        ambient_int_pending, low_power;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, wait_base_cycles, q;
   logic [11:0] wait_cycles;
   logic [15:0] clear_channel_result, ambient_low_threshold, ambient_high_threshold;
   int          bad_count, tests_run;
   light_persist_and_pulse_config dut (
      .ref_clk                (ref_clk),
      .rst                    (rst),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_write              (reg_write),
      .reg_read               (reg_read),
      .reg_rdata              (reg_rdata),
      .sample_start           (sample_start),
      .led_driver_output      (led_driver_output),
      .sample_busy            (sample_busy),
      .result_valid           (result_valid),
      .clear_channel_result   (clear_channel_result),
      .ambient_low_threshold  (ambient_low_threshold),
      .ambient_high_threshold (ambient_high_threshold),
      .ambient_int_clear      (ambient_int_clear),
      .ambient_int_pending    (ambient_int_pending),
      .wait_base_cycles       (wait_base_cycles),
      .wait_cycles            (wait_cycles),
      .functions_idle         (functions_idle),
      .low_power              (low_power)
   );
   host_port_model host (
      .ref_clk   (ref_clk),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_write (reg_write),
      .reg_read  (reg_read),
      .reg_rdata (reg_rdata)
   );
   initial
   begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("%0d compared, %0d wrong", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_regs;
      host.access(1, general_config_addr, 8'h24, q);
      host.access(0, general_config_addr, 8'h00, q);
      check(16'(q), 16'h0024);
      host.access(0, 8'h90, 8'h00, q);
      check(16'(q), 16'h0000);
      $display("regs done");
   endtask
   task automatic t_wait;
      functions_idle = 1;
      wait_base_cycles = 8'h0b;
      step(2);
      check(16'(wait_cycles), 16'd132);
      check(16'(low_power), 16'h0001);
      host.access(1, general_config_addr, 8'h00, q);
      step(2);
      check(16'(wait_cycles), 16'd11);
      check(16'(low_power), 16'h0000);
      $display("wait done");
   endtask
   // in-range value sits exactly on the high threshold: the compare is strict
   task automatic feed(input logic out);
      clear_channel_result = out ? 16'h0100 : 16'h00c0;
      result_valid = 1;
      step(1);
      result_valid = 0;
      step(1);
   endtask
   task automatic t_persist;
      int p[8] = '{0, 1, 2, 3, 4, 5, 14, 15};
      int req;
      for (int i = 0; i < 8; i++)
      begin
         req = p[i] < 4 ? p[i] : (p[i] == 4 ? 5 : 5 * (p[i] - 3));
         host.access(1, persistence_addr, 8'(p[i]), q);
         ambient_int_clear = 1;
         step(1);
         ambient_int_clear = 0;
         // the first in-range result empties a counter left saturated by the last setting
         if (req == 0)
            feed(0);
         else
         begin
            feed(0);
            repeat (req - 1) feed(1);
            check(16'(ambient_int_pending), 16'h0000);
            feed(0);
            repeat (req - 1) feed(1);
            check(16'(ambient_int_pending), 16'h0000);
            feed(1);
         end
         check(16'(ambient_int_pending), 16'h0001);
      end
      $display("persistence done");
   endtask
   task automatic t_pulse(input logic [1:0] len, input logic [5:0] cnt);
      int pulses, on, n;
      logic prev;
      host.access(1, pulse_config_addr, {len, cnt}, q);
      host.access(0, pulse_config_addr, 8'h00, q);
      check(16'(q), 16'({len, cnt}));
      {pulses, on, n, prev} = '0;
      sample_start = 1;
      step(1);
      sample_start = 0;
      check(16'(sample_busy), 16'h0001);
      do
      begin
         step(1);
         pulses += int'(led_driver_output && !prev);
         on += int'(led_driver_output);
         prev = led_driver_output;
         n++;
      end while (sample_busy && n < 20000);
      if (n >= 20000)
      begin
         bad_count++;
         summarize();
      end
      check(16'(pulses), 16'(cnt + 1));
      check(16'(on), 16'((cnt + 1) * (int'(pulse_base_cycles) << len)));
      $display("pulse train done");
   endtask
   initial
   begin
      {rst, sample_start, result_valid, ambient_int_clear, functions_idle} = 5'b10000;
      {clear_channel_result, wait_base_cycles, bad_count, tests_run} = '0;
      ambient_low_threshold = 16'h0040;
      ambient_high_threshold = 16'h00c0;
      repeat (3) @(posedge ref_clk);
      #1 rst = 0;
      t_regs();
      t_wait();
      t_persist();
      t_pulse(2'h0, 6'h3f);
      t_pulse(2'h1, 6'h00);
      t_pulse(2'h2, 6'h01);
      t_pulse(2'h3, 6'h02);
      summarize();
   end
endmodule // light_persist_and_pulse_config_test
`default_nettype wire
